// ### inc/arsc_pkg.sv
package arsc_pkg;
    // =====================================================
    // link shape
    localparam int N_CH = 2;
    localparam int WORD_BITS = 24;
    localparam logic [4:0] WORD_BITS_5 = 5'h18;
    // falls per frame: one per data bit, plus the one that ends ready
    localparam logic [4:0] FRAME_FALLS = 5'h19;
    // =====================================================
    // settling counts, in results
    localparam logic [5:0] SUPPRESS_SINC = 6'h04;
    localparam logic [5:0] SUPPRESS_FIR = 6'h3f;
    // =====================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MIN_PULSE_MCLK = 2;
    localparam int SCLK_PERIOD_NS = 200;
    localparam int SCLK_HALF_CYC =
        (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // extra cycles cover the far end's two-flop sampling
    localparam int PULSE_HOLD_CYC = MIN_PULSE_MCLK + 2;
    localparam int CONV_CYC_DEFAULT = 2048;
    localparam int FIFO_DEPTH_DEFAULT = 32;
    // =====================================================
    // values after reset
    localparam logic RDY_N_RST = 1'b1;
    localparam logic DOUT_RST = 1'b1;
    localparam logic CS_N_RST = 1'b1;
    localparam logic [2:0] PIN_HIGH_RST = 3'h7;
    // =====================================================
    // modes and states
    typedef enum logic [1:0] {
        ARSC_GPIO_IN = 2'h0,
        ARSC_GPIO_OUT = 2'h1,
        ARSC_GPIO_MODSYNC = 2'h2
    } arsc_gpio_mode_t;

    typedef enum logic [2:0] {
        ARSC_H_IDLE = 3'h0,
        ARSC_H_SETUP = 3'h1,
        ARSC_H_HIGH = 3'h3,
        ARSC_H_LOW = 3'h2,
        ARSC_H_HOLD = 3'h6,
        ARSC_H_GAP = 3'h7
    } arsc_host_state_t;
endpackage

// ### inc/arsc_link_if.sv
`timescale 1ns/1ps
interface arsc_link_if;
    import arsc_pkg::*;
    logic sclk;
    logic din;
    logic [N_CH-1:0] chip_select_n;
    logic [N_CH-1:0] filter_restart;
    logic [N_CH-1:0] digital_reset_n;
    logic dout_o [N_CH];
    logic dout_oe [N_CH];
    logic data_ready_n [N_CH];
    logic gpio_o [N_CH];
    logic gpio_oe [N_CH];
    // resolved wire levels
    logic dout;
    logic [N_CH-1:0] gpio_lvl;

    // =====================================================
    // wire resolution: shared data line idles high, pins pulled up
    always_comb begin
        dout = 1'b1;
        for (int i = 0; i < N_CH; i++) begin
            if (dout_oe[i]) begin
                dout = dout_o[i];
            end
            gpio_lvl[i] = gpio_oe[i] ? gpio_o[i] : 1'b1;
        end
    end

    modport device (
        input sclk, din, chip_select_n, filter_restart, digital_reset_n,
        input gpio_lvl,
        output dout_o, dout_oe, data_ready_n, gpio_o, gpio_oe
    );
    modport host (
        output sclk, din, chip_select_n, filter_restart, digital_reset_n,
        input dout, data_ready_n, gpio_lvl
    );
endinterface

// ### logic/arsc_device.sv
// Contract
// - restart input resets filter and modulator
// - restart held high two master clocks
// - reset low returns channel to defaults
// - reset held low two master clocks
// - restart input driven low normally
// - reset input driven high normally
// - ready rises on fall after last bit
// - ready rises within two clocks of restart; the code raises it on the third clock after restart rises
// - data line shows ready at select fall
// - data line released after select rises
// - data line changes after clock fall
// - host ends frame before extra edge
// - pin is input or output, input default
// - pin may output modulator sync pulse
// - ready goes low on new result
// - short filter skips first four results
// - long filter skips first sixty-three results
// - select high resets serial state
`timescale 1ns/1ps
module arsc_device
    import arsc_pkg::*;
#(
    parameter int CH = 0,
    parameter int CONV_CYC = CONV_CYC_DEFAULT
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic fir_sel_in,
    input wire logic [1:0] gpio_mode_in,
    input wire logic gpio_value_in,
    output logic gpio_level_out,
    output logic [WORD_BITS-1:0] result_out,
    arsc_link_if.device link
);
    // =====================================================
    // state
    localparam int CONV_W = $clog2(CONV_CYC);
    localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYC - 1);

    typedef struct packed {
        logic [2:0] sclk_q;
        logic [2:0] cs_q;
        logic [2:0] sync_q;
        logic [1:0] gpio_q;
        logic gpio_level;
        logic arm;
        logic [CONV_W-1:0] conv_cnt;
        logic [5:0] skip_cnt;
        logic [WORD_BITS-1:0] sample;
        logic [WORD_BITS-1:0] result;
        logic [WORD_BITS-1:0] shreg;
        logic [4:0] bit_cnt;
        logic in_frame;
        logic rdy_n;
        logic dout;
        logic dout_oe;
        logic mod_pulse;
        logic gpio_o;
        logic gpio_oe;
    } arsc_dev_st_t;

    localparam arsc_dev_st_t DEV_RST = '{
        cs_q: PIN_HIGH_RST,
        arm: 1'b1,
        rdy_n: RDY_N_RST,
        dout: DOUT_RST,
        default: '0
    };

    arsc_dev_st_t st;
    arsc_dev_st_t next_st;
    logic [1:0] rel_q;
    logic ch_rst_n;
    logic sync_hi;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    arsc_gpio_mode_t mode;

    function automatic logic [5:0] suppress_count(input logic fir);
        suppress_count = fir ? SUPPRESS_FIR : SUPPRESS_SINC;
    endfunction

    // edges of a synchronised pin: stage 2 against its delayed copy
    function automatic logic fell_edge(input logic [2:0] q);
        fell_edge = ~q[1] & q[2];
    endfunction

    function automatic logic rose_edge(input logic [2:0] q);
        rose_edge = q[1] & ~q[2];
    endfunction

    // =====================================================
    // channel reset: pin asserts at once, release is synchronised
    // the pin gates only this channel, so the other one runs on
    assign ch_rst_n = resetn_in & link.digital_reset_n[CH];

    always_ff @(posedge clk_sys_in or negedge ch_rst_n) begin
        if (!ch_rst_n) begin
            rel_q <= 2'h0;
        end else begin
            rel_q <= {rel_q[0], 1'b1};
        end
    end

    // =====================================================
    // next state
    always_comb begin
        next_st = st;
        mode = arsc_gpio_mode_t'(gpio_mode_in);
        // two-flop sampling; stage 2 and its delayed copy feed logic
        next_st.sclk_q = {st.sclk_q[1:0], link.sclk};
        next_st.cs_q = {st.cs_q[1:0], link.chip_select_n[CH]};
        next_st.sync_q = {st.sync_q[1:0], link.filter_restart[CH]};
        next_st.gpio_q = {st.gpio_q[0], link.gpio_lvl[CH]};
        next_st.gpio_level = st.gpio_q[1];
        next_st.mod_pulse = 1'b0;
        sync_hi = st.sync_q[1];
        cs_fall = fell_edge(st.cs_q);
        cs_rise = rose_edge(st.cs_q);
        sclk_fall = fell_edge(st.sclk_q);

        // serial side
        // a frame cut before fall 25 leaves ready low for the next one
        if (st.cs_q[1]) begin
            next_st.in_frame = 1'b0;
            next_st.bit_cnt = 5'h00;
            if (cs_rise) begin
                next_st.dout_oe = 1'b0;
            end
        end else if (cs_fall) begin
            next_st.in_frame = 1'b1;
            next_st.dout_oe = 1'b1;
            // low here tells the host a result is waiting
            next_st.dout = st.rdy_n;
            next_st.shreg = st.result;
            next_st.bit_cnt = 5'h00;
        end else if (st.in_frame && sclk_fall) begin
            if (st.bit_cnt < WORD_BITS_5) begin
                next_st.dout = st.shreg[WORD_BITS-1];
                next_st.shreg = {st.shreg[WORD_BITS-2:0], 1'b0};
                next_st.bit_cnt = st.bit_cnt + 5'h01;
            end else if (st.bit_cnt == WORD_BITS_5) begin
                next_st.rdy_n = 1'b1;
                // later falls in this frame are ignored
                next_st.bit_cnt = FRAME_FALLS;
            end
        end

        // conversion side; placed last so a new result beats the
        // ready clear of the same cycle
        if (st.arm) begin
            next_st.arm = 1'b0;
            next_st.skip_cnt = suppress_count(fir_sel_in);
        end else if (sync_hi) begin
            // held in restart for as long as the input stays high
            next_st.conv_cnt = '0;
            next_st.sample = '0;
            next_st.skip_cnt = suppress_count(fir_sel_in);
            next_st.rdy_n = 1'b1;
        end else if (st.conv_cnt == CONV_LAST) begin
            next_st.conv_cnt = '0;
            next_st.mod_pulse = 1'b1;
            next_st.sample = st.sample + 24'h000001;
            if (st.skip_cnt != 6'h00) begin
                next_st.skip_cnt = st.skip_cnt - 6'h01;
            end else begin
                // an unread result is overwritten; only the latest is kept
                next_st.result = st.sample;
                next_st.rdy_n = 1'b0;
            end
        end else begin
            next_st.conv_cnt = st.conv_cnt + CONV_W'(1);
        end

        // general-purpose pin
        // input is the reset default, so the pin rests on its pull-up
        next_st.gpio_oe = (mode != ARSC_GPIO_IN);
        if (mode == ARSC_GPIO_MODSYNC) begin
            next_st.gpio_o = next_st.mod_pulse;
        end else begin
            next_st.gpio_o = gpio_value_in;
        end
    end

    // =====================================================
    // registers
    // reset timing comes from the release flops, not from the pin
    always_ff @(posedge clk_sys_in or negedge rel_q[1]) begin
        if (!rel_q[1]) begin
            st <= DEV_RST;
        end else begin
            st <= next_st;
        end
    end

    // =====================================================
    // outputs
    assign link.dout_o[CH] = st.dout;
    assign link.dout_oe[CH] = st.dout_oe;
    assign link.data_ready_n[CH] = st.rdy_n;
    assign link.gpio_o[CH] = st.gpio_o;
    assign link.gpio_oe[CH] = st.gpio_oe;
    assign gpio_level_out = st.gpio_level;
    assign result_out = st.result;
endmodule // arsc_device

// ### logic/arsc_host.sv
`timescale 1ns/1ps
module arsc_fifo #(
    parameter int W = 25,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } arsc_fifo_st_t;

    arsc_fifo_st_t st;
    arsc_fifo_st_t next_st;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // =====================================================
    // pointers
    always_comb begin
        next_st = st;
        push = in_valid_in && (st.cnt != FULL);
        pop = out_ready_in && (st.cnt != '0);
        if (push) begin
            next_st.wr = st.wr + AW'(1);
        end
        if (pop) begin
            next_st.rd = st.rd + AW'(1);
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + (AW + 1)'(1);
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - (AW + 1)'(1);
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem[st.wr] <= in_data_in;
        end
    end

    assign in_ready_out = (st.cnt != FULL);
    assign out_valid_out = (st.cnt != '0);
    assign out_data_out = mem[st.rd];
endmodule // arsc_fifo

module arsc_host
    import arsc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH_DEFAULT
) (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic [N_CH-1:0] sync_req_in,
    input wire logic [N_CH-1:0] reset_req_in,
    output logic word_valid_out,
    output logic [WORD_BITS:0] word_data_out,
    input wire logic word_ready_in,
    output logic [N_CH-1:0] gpio_level_out,
    arsc_link_if.host link
);
    // =====================================================
    // state
    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
    localparam logic [3:0] HOLD = 4'(PULSE_HOLD_CYC);

    typedef struct packed {
        arsc_host_state_t fsm;
        logic ch;
        logic [7:0] cnt;
        logic [4:0] falls;
        logic [WORD_BITS:0] sh;
        logic sclk;
        logic [N_CH-1:0] cs_n;
        logic [N_CH-1:0][3:0] sync_cnt;
        logic [N_CH-1:0][3:0] rst_cnt;
        logic [N_CH-1:0] sync;
        logic [N_CH-1:0] rst_n;
        logic [1:0] dout_q;
        logic [N_CH-1:0][1:0] rdy_q;
        logic [N_CH-1:0][1:0] gpio_q;
        logic push;
        logic [WORD_BITS:0] push_data;
    } arsc_host_st_t;

    localparam arsc_host_st_t HOST_RST = '{
        fsm: ARSC_H_IDLE,
        cs_n: {N_CH{CS_N_RST}},
        rst_n: {N_CH{1'b1}},
        dout_q: 2'h3,
        rdy_q: {N_CH{2'h3}},
        gpio_q: {N_CH{2'h3}},
        default: '0
    };

    arsc_host_st_t st;
    arsc_host_st_t next_st;
    logic fifo_ready;
    logic busy;

    // =====================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.push = 1'b0;
        next_st.dout_q = {st.dout_q[0], link.dout};
        for (int i = 0; i < N_CH; i++) begin
            next_st.rdy_q[i] = {st.rdy_q[i][0], link.data_ready_n[i]};
            next_st.gpio_q[i] = {st.gpio_q[i][0], link.gpio_lvl[i]};
            // pulses stretched past the two-clock minimum
            if (sync_req_in[i]) begin
                next_st.sync_cnt[i] = HOLD;
            end else if (st.sync_cnt[i] != 4'h0) begin
                next_st.sync_cnt[i] = st.sync_cnt[i] - 4'h1;
            end
            if (reset_req_in[i]) begin
                next_st.rst_cnt[i] = HOLD;
            end else if (st.rst_cnt[i] != 4'h0) begin
                next_st.rst_cnt[i] = st.rst_cnt[i] - 4'h1;
            end
            next_st.sync[i] = (next_st.sync_cnt[i] != 4'h0);
            next_st.rst_n[i] = (next_st.rst_cnt[i] == 4'h0);
        end
        busy = (st.sync_cnt[st.ch] != 4'h0) || (st.rst_cnt[st.ch] != 4'h0);
        if (st.fsm != ARSC_H_IDLE && st.cnt != 8'h00) begin
            next_st.cnt = st.cnt - 8'h01;
        end else begin
            next_st.cnt = HALF_LAST;
            case (st.fsm)
                ARSC_H_IDLE: begin
                    if (fifo_ready && !busy && !st.rdy_q[st.ch][1]) begin
                        next_st.cs_n[st.ch] = 1'b0;
                        next_st.falls = 5'h00;
                        next_st.fsm = ARSC_H_SETUP;
                    end else begin
                        next_st.ch = ~st.ch;
                    end
                end
                ARSC_H_SETUP, ARSC_H_LOW: begin
                    next_st.sclk = 1'b1;
                    // sampled a half period after the select fall or the clock fall on which the device changes
                    next_st.sh = {st.sh[WORD_BITS-1:0], st.dout_q[1]};
                    next_st.fsm = ARSC_H_HIGH;
                end
                ARSC_H_HIGH: begin
                    next_st.sclk = 1'b0;
                    next_st.falls = st.falls + 5'h01;
                    if (st.falls + 5'h01 == FRAME_FALLS) begin
                        next_st.fsm = ARSC_H_HOLD;
                    end else begin
                        next_st.fsm = ARSC_H_LOW;
                    end
                end
                ARSC_H_HOLD: begin
                    next_st.cs_n = {N_CH{1'b1}};
                    next_st.push = ~st.sh[WORD_BITS];
                    next_st.push_data = {st.ch, st.sh[WORD_BITS-1:0]};
                    next_st.fsm = ARSC_H_GAP;
                end
                ARSC_H_GAP: begin
                    next_st.ch = ~st.ch;
                    next_st.fsm = ARSC_H_IDLE;
                end
                default: begin
                    next_st.fsm = ARSC_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st <= HOST_RST;
        end else begin
            st <= next_st;
        end
    end

    // =====================================================
    // buffer; a frame starts only when a slot is free
    arsc_fifo #(
        .W(WORD_BITS + 1),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .in_valid_in(st.push),
        .in_data_in(st.push_data),
        .in_ready_out(fifo_ready),
        .out_valid_out(word_valid_out),
        .out_data_out(word_data_out),
        .out_ready_in(word_ready_in)
    );

    // =====================================================
    // outputs
    assign link.sclk = st.sclk;
    assign link.din = 1'b0;
    assign link.chip_select_n = st.cs_n;
    assign link.filter_restart = st.sync;
    assign link.digital_reset_n = st.rst_n;
    always_comb begin
        for (int i = 0; i < N_CH; i++) begin
            gpio_level_out[i] = st.gpio_q[i][1];
        end
    end
endmodule // arsc_host

// ### bench/arsc_link_props.sv
`timescale 1ns/1ps
module arsc_link_props
    import arsc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic sclk,
    input wire logic [N_CH-1:0] chip_select_n,
    input wire logic [N_CH-1:0] filter_restart,
    input wire logic [N_CH-1:0] digital_reset_n,
    input wire logic dout_o [N_CH],
    input wire logic dout_oe [N_CH],
    input wire logic data_ready_n [N_CH],
    input wire logic dout
);
    // =====================================================
    // serial clock falls counted within a channel-0 frame
    logic sclk_q;
    logic [4:0] falls;
    logic fall;
    assign fall = sclk_q && !sclk;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sclk_q <= 1'b0;
            falls <= 5'h00;
        end else begin
            sclk_q <= sclk;
            if (chip_select_n[0]) begin
                falls <= 5'h00;
            end else if (fall) begin
                falls <= falls + 5'h01;
            end
        end
    end
    // =====================================================
    // properties
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    AST_RDY_RESTART: assert property (
        $rose(filter_restart[0]) |-> ##[1:4] data_ready_n[0])
        else $error("ready not raised after restart");
    AST_RDY_HELD: assert property (
        filter_restart[0] [*4] |=> data_ready_n[0])
        else $error("ready low during restart");
    AST_RDY_RESET: assert property (
        !digital_reset_n[1] |-> data_ready_n[1] && !dout_oe[1])
        else $error("channel not in default state in reset");
    AST_RDY_CAUSE: assert property (
        $fell(data_ready_n[1]) |-> !filter_restart[1] && chip_select_n[1])
        else $error("ready fell without a new result");
    AST_RDY_LAST: assert property (
        fall && !chip_select_n[0] && falls == FRAME_FALLS - 5'h01
        |-> ##[1:6] data_ready_n[0])
        else $error("ready not raised after last fall");
    AST_DOUT_START: assert property (
        $fell(chip_select_n[0]) |-> dout
        ##[1:4] (dout_oe[0] && dout_o[0] == data_ready_n[0]))
        else $error("data line wrong at select fall");
    AST_DOUT_RELEASE: assert property (
        $rose(chip_select_n[0]) |-> ##[1:4] !dout_oe[0])
        else $error("data line not released");
    AST_DOUT_IDLE: assert property (
        chip_select_n[1] [*5] |-> !dout_oe[1])
        else $error("data line driven while deselected");
    AST_DOUT_EDGE: assert property (
        dout_oe[0] && $changed(dout_o[0]) |-> !sclk)
        else $error("data line changed while clock high");
endmodule // arsc_link_props

// ### bench/tb_adc_reset_sync_ready_control.sv
`timescale 1ns/1ps
module tb_adc_reset_sync_ready_control
    import arsc_pkg::*;
;
    // long enough conversions that both channels fit a frame each
    localparam int CONV = 1200;
    logic clk_sys_in;
    logic resetn_in;
    logic [N_CH-1:0] sync_req;
    logic [N_CH-1:0] reset_req;
    logic word_ready_in;
    logic word_valid;
    logic [WORD_BITS:0] word_data;
    logic [WORD_BITS:0] w;
    logic [N_CH-1:0] host_gpio;
    logic [N_CH-1:0] dev_gpio;
    logic [WORD_BITS-1:0] dev_result [N_CH];
    logic [N_CH-1:0] fir_sel;
    logic [N_CH-1:0] gpio_val;
    logic [1:0] gpio_mode [N_CH];
    logic [WORD_BITS-1:0] exp_val [N_CH];
    logic prev;
    int n_errors, check_count, cyc, t0, n, n0, n1;

    arsc_link_if arsc_link_if_i ();
    arsc_device #(.CH(0), .CONV_CYC(CONV)) arsc_device_i (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .fir_sel_in(fir_sel[0]), .gpio_mode_in(gpio_mode[0]),
        .gpio_value_in(gpio_val[0]), .gpio_level_out(dev_gpio[0]),
        .result_out(dev_result[0]), .link(arsc_link_if_i.device));
    arsc_device #(.CH(1), .CONV_CYC(CONV)) arsc_device_ch1_i (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .fir_sel_in(fir_sel[1]), .gpio_mode_in(gpio_mode[1]),
        .gpio_value_in(gpio_val[1]), .gpio_level_out(dev_gpio[1]),
        .result_out(dev_result[1]), .link(arsc_link_if_i.device));
    arsc_host #(.DEPTH(FIFO_DEPTH_DEFAULT)) arsc_host_i (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .sync_req_in(sync_req), .reset_req_in(reset_req),
        .word_valid_out(word_valid), .word_data_out(word_data),
        .word_ready_in(word_ready_in), .gpio_level_out(host_gpio),
        .link(arsc_link_if_i.host));
    arsc_link_props arsc_link_props_i (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .sclk(arsc_link_if_i.sclk),
        .chip_select_n(arsc_link_if_i.chip_select_n),
        .filter_restart(arsc_link_if_i.filter_restart),
        .digital_reset_n(arsc_link_if_i.digital_reset_n),
        .dout_o(arsc_link_if_i.dout_o), .dout_oe(arsc_link_if_i.dout_oe),
        .data_ready_n(arsc_link_if_i.data_ready_n),
        .dout(arsc_link_if_i.dout));

    // =====================================================
    // clock and cycle ceiling
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            $display("Error %0t: run too long", $time);
            end_sim();
        end
    end
    // =====================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // pops one word; an extra edge keeps ready from toggling twice
    task automatic pop();
        int k;
        k = 0;
        while (word_valid !== 1'b1 && k < 3000) begin
            @(negedge clk_sys_in);
            k++;
        end
        if (k >= 3000) begin
            n_errors++;
            $display("Error %0t: no word arrived", $time);
        end
        w = word_data;
        word_ready_in = 1'b1;
        @(negedge clk_sys_in);
        word_ready_in = 1'b0;
        @(negedge clk_sys_in);
    endtask
    task automatic flush();
        while (word_valid === 1'b1) begin
            pop();
        end
    endtask
    task automatic wait_until(input int t);
        while (cyc < t) begin
            @(negedge clk_sys_in);
        end
    endtask
    task end_sim;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // =====================================================
    // tests
    initial begin
        resetn_in = 1'b0;
        sync_req = 2'h0;
        reset_req = 2'h0;
        word_ready_in = 1'b0;
        fir_sel = 2'h0;
        gpio_val = 2'h0;
        gpio_mode[0] = ARSC_GPIO_IN;
        gpio_mode[1] = ARSC_GPIO_IN;
        repeat (3) @(negedge clk_sys_in);
        resetn_in = 1'b1;
        t0 = cyc;
        repeat (10) @(negedge clk_sys_in);
        chk(host_gpio, 2'h3);
        chk(dev_gpio, 2'h3);
        gpio_mode[0] = ARSC_GPIO_OUT;
        for (int v = 0; v < 2; v++) begin
            gpio_val[0] = v[0];
            repeat (10) @(negedge clk_sys_in);
            chk(host_gpio[0], v[0]);
            chk(dev_gpio[0], v[0]);
        end
        gpio_mode[1] = ARSC_GPIO_MODSYNC;
        prev = arsc_link_if_i.gpio_lvl[1];
        n = 0;
        repeat (CONV + 100) begin
            @(negedge clk_sys_in);
            if (arsc_link_if_i.gpio_lvl[1] !== prev) n++;
            prev = arsc_link_if_i.gpio_lvl[1];
        end
        chk(n >= 2, 1);
        gpio_mode[0] = ARSC_GPIO_IN;
        gpio_mode[1] = ARSC_GPIO_IN;
        // settling results stay hidden; consumer stalls to fill fifo
        wait_until(t0 + 4 * CONV + 100);
        chk(word_valid, 0);
        chk({arsc_link_if_i.data_ready_n[1],
            arsc_link_if_i.data_ready_n[0]}, 2'h3);
        wait_until(t0 + 26000);
        exp_val[0] = 24'h000004;
        exp_val[1] = 24'h000004;
        for (int k = 0; k < 32; k++) begin
            pop();
            chk(w[WORD_BITS-1:0], exp_val[w[WORD_BITS]]);
            exp_val[w[WORD_BITS]]++;
        end
        chk(word_valid, 0);
        chk(dev_result[0], exp_val[0]);
        chk(dev_result[1], exp_val[1]);
        // restart channel 0: count restarts, other channel runs on
        sync_req = 2'h1;
        @(negedge clk_sys_in);
        sync_req = 2'h0;
        t0 = cyc;
        wait_until(t0 + 2000);
        flush();
        n1 = 0;
        w[WORD_BITS] = 1'b1;
        while (w[WORD_BITS] !== 1'b0 && cyc < t0 + 9000) begin
            pop();
            if (w[WORD_BITS] === 1'b1) n1++;
        end
        chk(w[WORD_BITS-1:0], 24'h000004);
        chk(cyc - t0 >= 5 * CONV, 1);
        chk(n1 >= 3, 1);
        // reset channel 1 into long filter: stays silent a long time
        fir_sel[1] = 1'b1;
        reset_req = 2'h2;
        @(negedge clk_sys_in);
        reset_req = 2'h0;
        t0 = cyc;
        wait_until(t0 + 2000);
        flush();
        n0 = 0;
        n1 = 0;
        while (cyc < t0 + 10000) begin
            pop();
            if (w[WORD_BITS] === 1'b1) n1++;
            else n0++;
        end
        chk(n1, 0);
        chk(n0 >= 5, 1);
        end_sim();
    end
endmodule // tb_adc_reset_sync_ready_control
